/* hdl/tlb_entry_staging_regs.v */
// Function
// R1 - Entry registers are the only path between TLB and read/write instructions
// R2 - Even page goes through first entry register, odd page through second
// R3 - Entry registers may be undefined after address or TLB exceptions
// R4 - Top two entry bits read zero and ignore writes
// R5 - Software writes zero to bits 29:26; they reset to zero
// R6 - Frame number held in bits 25:6, gives physical address 31:12
// R7 - Coherency 0,1,3,4,5,6 cached write-through; 2,7 uncached
// R8 - Code 7 behaves as 2; other unused codes behave as 3
// R9 - Write-permit zero makes a store raise TLB Modified
// R10 - Valid zero makes any access raise TLB Invalid
// R11 - TLB write stores AND of both global bits
// R12 - Global entry ignores address-space tag compare
// R13 - TLB read copies global bit into both entry registers
// R14 - TLB exception loads VA 31:13 into pointer bits 22:4
// R15 - Faulting-page field is hardware-written only
// R16 - Faulting-page field may be undefined after address error
// R17 - Table base in top nine bits is software read/write only
// R18 - Low four pointer bits read zero
// R19 - Read and indexed write select entry by index register
// R20 - Random write selects entry by random register
// R21 - Even/odd half chosen by VA bit above page offset
`timescale 1ns/1ps
`include "tlb_stage_defs.vh"

module tlb_entry_staging_regs (
    input  wire        REF_CLK,
    input  wire        SYS_RST,
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);

////////////////////////////////////////////////////////////////////////////////
// Storage
reg  [31:0] even_q;
reg  [31:0] odd_q;
reg  [31:0] ptr_q;
reg  [3:0]  index_q;
reg  [3:0]  wired_q;
reg  [3:0]  random_q;
reg  [7:0]  lfsr_q;
reg  [11:0] mask_q;
reg  [18:0] vpair_q;
reg  [7:0]  tag_q;
reg  [31:0] xva_q;
reg  [31:0] xres_q;
reg  [7:0]  aw_q;
reg  [31:0] wd_q;
reg  [3:0]  ws_q;
reg         aw_ok_q;
reg         w_ok_q;

// TLB array in flip-flops
reg  [18:0] t_vpn   [0:`TLB_ENTRIES-1];
reg  [7:0]  t_tag   [0:`TLB_ENTRIES-1];
reg  [11:0] t_mask  [0:`TLB_ENTRIES-1];
reg         t_glob  [0:`TLB_ENTRIES-1];
reg  [24:0] t_even  [0:`TLB_ENTRIES-1];
reg  [24:0] t_odd   [0:`TLB_ENTRIES-1];

wire        do_wr   = aw_ok_q & w_ok_q & ~S_AXI_BVALID;
wire [2:0]  wr_idx  = aw_q[4:2];
wire        wr_ent  = do_wr && aw_q[7:5] == 3'h0;
wire        wr_ctl  = do_wr && aw_q == `ADDR_CTRL;
wire        wr_xl   = do_wr && aw_q == `ADDR_XLATE;
wire [31:0] wmask   = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

wire        op_read  = wr_ctl & wd_q[`CTL_READ] & ws_q[0];
wire        op_wi    = wr_ctl & wd_q[`CTL_WRITE_IDX] & ws_q[0];
wire        op_wr    = wr_ctl & wd_q[`CTL_WRITE_RAND] & ws_q[0];
wire        op_exc   = wr_ctl & wd_q[`CTL_EXC_TLB] & ws_q[0];
// R19 R20
wire [3:0]  sel_idx  = op_wr ? random_q : index_q;

// Packed entry halves hold frame number, coherency, write-permit, valid
wire [24:0] even_pk = even_q[`PFN_HI:`WPERM_BIT-1];
wire [24:0] odd_pk  = odd_q[`PFN_HI:`WPERM_BIT-1];

////////////////////////////////////////////////////////////////////////////////
// Translation lookup of xva_q
wire [15:0] hit_v;
genvar g;
// Masked page-pair compare; global entries skip the tag compare
generate
    for (g = 0; g < `TLB_ENTRIES; g = g + 1) begin : g_match
        assign hit_v[g] = ((t_vpn[g] ^ xva_q[31:13]) & ~{7'h00, t_mask[g]}) == 19'h00000
                          && (t_glob[g] || t_tag[g] == tag_q); // R12
    end
endgenerate

reg  [3:0]  hit_i;
reg         hit;
reg         odd_sel;
reg  [24:0] half;
reg  [2:0]  coh;
reg  [31:0] res_d;
integer     k;
// Lowest matching index wins when entries overlap
always @* begin
    hit_i = 4'h0;
    hit   = 1'b0;
    for (k = 0; k < `TLB_ENTRIES; k = k + 1) begin
        if (hit_v[k] && !hit) begin
            hit   = 1'b1;
            hit_i = k[3:0];
        end
    end
    // R21
    case (t_mask[hit_i])
        12'h003: odd_sel = xva_q[14];
        12'h00F: odd_sel = xva_q[16];
        12'h03F: odd_sel = xva_q[18];
        12'h0FF: odd_sel = xva_q[20];
        12'h3FF: odd_sel = xva_q[22];
        12'hFFF: odd_sel = xva_q[24];
        default: odd_sel = xva_q[12];
    endcase
    half = odd_sel ? t_odd[hit_i] : t_even[hit_i];
    // R7 R8
    case (half[4:2])
        `COH_UNCACHED:   coh = `COH_UNCACHED;
        `COH_UNUSED_UNC: coh = `COH_UNCACHED;
        default:         coh = `COH_CACHED;
    endcase
    res_d = 32'h00000000;
    res_d[31:12] = half[24:5]; // R6
    res_d[11:9]  = coh;
    res_d[8]     = coh == `COH_UNCACHED;
    res_d[7]     = hit;
    res_d[6]     = hit & ~half[0]; // R10
    res_d[5]     = hit & half[0] & xva_q[0] & ~half[1]; // R9
end

////////////////////////////////////////////////////////////////////////////////
// Bus slave and register updates
always @(posedge REF_CLK) begin
    if (SYS_RST) begin
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
        S_AXI_BVALID  <= 1'b0;
        S_AXI_BRESP   <= 2'h0;
        S_AXI_ARREADY <= 1'b1;
        S_AXI_RVALID  <= 1'b0;
        S_AXI_RRESP   <= 2'h0;
        S_AXI_RDATA   <= 32'h00000000;
        aw_ok_q <= 1'b0;
        w_ok_q  <= 1'b0;
        aw_q    <= 8'h00;
        wd_q    <= 32'h00000000;
        ws_q    <= 4'h0;
        even_q  <= `ENTRY_RESET; // R5
        odd_q   <= `ENTRY_RESET; // R5
        ptr_q   <= `PTR_RESET;
        index_q <= 4'h0;
        wired_q <= `WIRED_RESET;
        random_q <= `TLB_TOP;
        lfsr_q  <= `LFSR_SEED;
        mask_q  <= 12'h000;
        vpair_q <= 19'h00000;
        tag_q   <= 8'h00;
        xva_q   <= 32'h00000000;
        xres_q  <= 32'h00000000;
    end else begin
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_q <= S_AXI_AWADDR;
            aw_ok_q <= 1'b1;
            S_AXI_AWREADY <= 1'b0;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            wd_q <= S_AXI_WDATA;
            ws_q <= S_AXI_WSTRB;
            w_ok_q <= 1'b1;
            S_AXI_WREADY <= 1'b0;
        end
        // Write lands once address and data are both held
        if (do_wr) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (aw_q[1:0] == 2'h0 && (wr_ent || wr_ctl || wr_xl))
                            ? 2'h0 : 2'h2;
        end
        if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID  <= 1'b0;
            aw_ok_q <= 1'b0;
            w_ok_q  <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
        end
        // Random walks down from the top entry to wired; the LFSR stalls it at times
        lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        if (!lfsr_q[0])
            random_q <= (random_q == wired_q) ? `TLB_TOP : random_q - 4'h1;
        if (wr_ent) begin
            case (wr_idx)
                `IDX_EVEN_ENTRY: // R1 R4
                    even_q <= ((even_q & ~wmask) | (wd_q & wmask)) & 32'h3FFFFFFF;
                `IDX_ODD_ENTRY: // R4
                    odd_q <= ((odd_q & ~wmask) | (wd_q & wmask)) & 32'h3FFFFFFF;
                `IDX_TABLE_PTR: // R15 R17
                    ptr_q[`BASE_HI:`BASE_LO] <= (ptr_q[31:23] & ~wmask[31:23])
                                               | (wd_q[31:23] & wmask[31:23]);
                `IDX_INDEX:     if (ws_q[0]) index_q <= wd_q[3:0];
                `IDX_WIRED: if (ws_q[0]) begin
                    wired_q  <= wd_q[3:0];
                    random_q <= `TLB_TOP;
                end
                `IDX_PAGE_MASK: if (ws_q[3] & ws_q[1]) mask_q <= wd_q[24:13];
                `IDX_VPAIR: if (&ws_q) begin
                    vpair_q <= wd_q[31:13];
                    tag_q   <= wd_q[7:0];
                end
                default: ;
            endcase
        end
        if (wr_xl) begin
            xva_q <= wd_q;
        end
        xres_q <= res_d;
        if (op_read) begin // R1 R2 R13
            even_q <= {6'h00, t_even[index_q], t_glob[index_q]};
            odd_q  <= {6'h00, t_odd[index_q],  t_glob[index_q]};
            vpair_q <= t_vpn[index_q];
            tag_q   <= t_tag[index_q];
            mask_q  <= t_mask[index_q];
        end
        // Entry registers keep their values; software must not rely on them here
        if (op_exc) begin // R14 R3 R16
            ptr_q[`FPAGE_HI:`FPAGE_LO] <= xva_q[31:13];
            vpair_q <= xva_q[31:13];
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RRESP   <= 2'h0;
            if (S_AXI_ARADDR[7:5] == 3'h0 && S_AXI_ARADDR[1:0] == 2'h0) begin
                case (S_AXI_ARADDR[4:2])
                    `IDX_EVEN_ENTRY: S_AXI_RDATA <= {2'h0, even_q[29:0]}; // R4
                    `IDX_ODD_ENTRY:  S_AXI_RDATA <= {2'h0, odd_q[29:0]};
                    `IDX_TABLE_PTR:  S_AXI_RDATA <= {ptr_q[31:4], 4'h0}; // R18
                    `IDX_INDEX:      S_AXI_RDATA <= {28'h0000000, index_q};
                    `IDX_RANDOM:     S_AXI_RDATA <= {28'h0000000, random_q};
                    `IDX_WIRED:      S_AXI_RDATA <= {28'h0000000, wired_q};
                    `IDX_PAGE_MASK:  S_AXI_RDATA <= {7'h00, mask_q, 13'h0000};
                    default:         S_AXI_RDATA <= {vpair_q, 5'h00, tag_q};
                endcase
            end else if (S_AXI_ARADDR == `ADDR_XLATE) begin
                S_AXI_RDATA <= xva_q;
            end else if (S_AXI_ARADDR == `ADDR_XRESULT) begin
                S_AXI_RDATA <= xres_q;
            end else if (S_AXI_ARADDR == `ADDR_CTRL) begin
                S_AXI_RDATA <= 32'h00000000;
            end else begin
                // Unmapped or misaligned reads answer zero with an error
                S_AXI_RDATA <= 32'h00000000;
                S_AXI_RRESP <= 2'h2;
            end
        end
        if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// TLB array writes
generate
    for (g = 0; g < `TLB_ENTRIES; g = g + 1) begin : g_tlb
        always @(posedge REF_CLK) begin
            if (SYS_RST) begin
                t_vpn[g]  <= 19'h00000;
                t_tag[g]  <= 8'h00;
                t_mask[g] <= 12'h000;
                t_glob[g] <= 1'b0;
                t_even[g] <= 25'h0000000;
                t_odd[g]  <= 25'h0000000;
            end else if ((op_wi || op_wr) && sel_idx == g) begin // R19 R20
                t_vpn[g]  <= vpair_q;
                t_tag[g]  <= tag_q;
                t_mask[g] <= mask_q;
                t_glob[g] <= even_q[`GLOBAL_BIT] & odd_q[`GLOBAL_BIT]; // R11
                t_even[g] <= even_pk; // R2
                t_odd[g]  <= odd_pk;
            end
        end
    end
endgenerate

endmodule

/* hdl/tlb_stage_defs.vh */
`ifndef TLB_STAGE_DEFS_VH
`define TLB_STAGE_DEFS_VH

// Register word indices, byte address four times the index; ADDR_CTRL, ADDR_XLATE and ADDR_XRESULT are byte addresses
`define IDX_EVEN_ENTRY    3'h2
`define IDX_ODD_ENTRY     3'h3
`define IDX_TABLE_PTR     3'h4
`define IDX_INDEX         3'h0
`define IDX_RANDOM        3'h1
`define IDX_WIRED         3'h6
`define IDX_PAGE_MASK     3'h5
`define IDX_VPAIR         3'h7
`define ADDR_CTRL         8'h20
`define ADDR_XLATE        8'h24
`define ADDR_XRESULT      8'h28

// Entry field positions
`define ENT_RSV_HI        31
`define ENT_RSV_LO        30
`define ENT_ZERO_HI       29
`define ENT_ZERO_LO       26
`define PFN_HI            25
`define PFN_LO            6
`define COH_HI            5
`define COH_LO            3
`define WPERM_BIT         2
`define VALID_BIT         1
`define GLOBAL_BIT        0

// Pointer field positions
`define BASE_HI           31
`define BASE_LO           23
`define FPAGE_HI          22
`define FPAGE_LO          4

// Coherency codes
`define COH_UNCACHED      3'h2
`define COH_CACHED        3'h3
`define COH_UNUSED_UNC    3'h7

// TLB geometry and reset values
`define TLB_ENTRIES       16
`define TLB_TOP           4'hF
`define WIRED_RESET       4'h0
`define LFSR_SEED         8'hA5
`define ENTRY_RESET       32'h00000000
`define PTR_RESET         32'h00000000

// Control register bits
`define CTL_READ          0
`define CTL_WRITE_IDX     1
`define CTL_WRITE_RAND    2
`define CTL_EXC_TLB       3
`define CTL_EXC_ADDR      4

`endif

/* verification/tlb_entry_staging_regs_bench.sv */
`timescale 1ns/1ps
`include "tlb_stage_defs.vh"
`define CHK(nm, ex, sn) begin \
    n_compared = n_compared + 1; \
    if ((sn) !== (ex)) begin \
        n_mismatch = n_mismatch + 1; \
        $display("Error %s expected %h seen %h", nm, ex, sn); \
    end \
end
module tlb_entry_staging_regs_bench;
    localparam [7:0]  a_idx = {3'h0, `IDX_INDEX, 2'h0};
    localparam [7:0]  a_rnd = {3'h0, `IDX_RANDOM, 2'h0};
    localparam [7:0]  a_wired = {3'h0, `IDX_WIRED, 2'h0};
    localparam [7:0]  a_vpair = {3'h0, `IDX_VPAIR, 2'h0};
    localparam [7:0]  a_even = {3'h0, `IDX_EVEN_ENTRY, 2'h0};
    localparam [7:0]  a_odd = {3'h0, `IDX_ODD_ENTRY, 2'h0};
    localparam [7:0]  a_ptr = {3'h0, `IDX_TABLE_PTR, 2'h0};
    localparam [18:0] vpn = 19'h2AAAA;
    localparam [19:0] pfe = 20'h12345;
    localparam [19:0] pfo = 20'hABCDE;
    reg         REF_CLK = 1'b0;
    reg         SYS_RST = 1'b1;
    wire [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
    wire [31:0] S_AXI_WDATA, S_AXI_RDATA;
    wire [3:0]  S_AXI_WSTRB;
    wire [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    wire        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
    wire        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    integer     n_mismatch = 0, n_compared = 0, cycles = 0, k;
    reg  [31:0] rv, ex, mk;
    reg  [1:0]  rr;
    reg  [19:0] row;
    reg         hit;
    // Row: expected hit, invalid, modified, uncached; then coherency, write permit,
    // valid, global, store, odd half, current tag
    logic [19:0] rows [0:7] = '{20'h81A11, 20'hA2B11, 20'h95811, 20'hC7111,
                                20'h88811, 20'h8BF22, 20'h0D822, 20'h9F911};

    tlb_entry_staging_regs dut (.*);
    tlb_stage_host m (.*);

    always begin
        #4 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict;
        end
    end
    task give_verdict;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task w(input [7:0] a, input [31:0] d);
        begin
            m.wr(a, d, rr);
            `CHK("bresp", 2'h0, rr)
        end
    endtask
    task rc(input [7:0] a, input [31:0] e);
        begin
            m.rd(a, rv, rr);
            `CHK("rdata", e, rv)
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        rc(a_even, 32'h0);
        rc(a_ptr, 32'h0);
        $display("reset test done");
        w(a_even, 32'hFFFFFFFF);
        rc(a_even, 32'h3FFFFFFF);
        w(a_ptr, 32'hFFFFFFFF);
        rc(a_ptr, 32'hFF800000);
        w(`ADDR_XLATE, 32'hABCDE000);
        w(`ADDR_CTRL, 32'h8);
        rc(a_ptr, 32'hFF800000 | ((32'hABCDE000 >> 13) << 4));
        $display("pointer test done");
        w(a_idx, 32'h5);
        w(a_even, 32'h1);
        w(a_odd, 32'h0);
        w(`ADDR_CTRL, 32'h2);
        w(a_even, 32'h41);
        w(a_odd, 32'h41);
        w(`ADDR_CTRL, 32'h1);
        rc(a_even, 32'h0);
        rc(a_odd, 32'h0);
        w(a_even, 32'h1);
        w(a_odd, 32'h1);
        w(`ADDR_CTRL, 32'h2);
        w(a_even, 32'h0);
        w(`ADDR_CTRL, 32'h1);
        rc(a_even, 32'h1);
        rc(a_odd, 32'h1);
        $display("global test done");
        w(a_idx, 32'h3);
        for (k = 0; k < 8; k = k + 1) begin
            row = rows[k];
            w(a_vpair, {vpn, 5'h0, 8'h11});
            w(a_even, {6'h0, pfe, row[15:10]});
            w(a_odd, {6'h0, pfo, row[15:10]});
            w(`ADDR_CTRL, 32'h2);
            w(a_vpair, {vpn, 5'h0, row[7:0]});
            w(`ADDR_XLATE, {vpn, row[8], 11'h0, row[9]});
            m.rd(`ADDR_XRESULT, rv, rr);
            hit = row[19];
            ex = {row[8] ? pfo : pfe, row[16] ? 4'h5 : 4'h6, row[19:17], 5'h0};
            mk = hit ? 32'hFFFFFFE0 : 32'h00000080;
            `CHK("xlate", ex & mk, rv & mk)
        end
        $display("translate test done");
        w(a_wired, 32'hF);
        rc(a_rnd, 32'hF);
        w(a_even, 32'h00ABC01E);
        w(`ADDR_CTRL, 32'h4);
        w(a_idx, 32'hF);
        w(a_even, 32'h0);
        w(`ADDR_CTRL, 32'h1);
        rc(a_even, 32'h00ABC01E);
        $display("random write test done");
        m.slow = 3;
        m.rd(8'h3C, rv, rr);
        `CHK("unmapped rresp", 2'h2, rr)
        m.wr(8'h3C, 32'h1, rr);
        `CHK("unmapped bresp", 2'h2, rr)
        rc(a_even, 32'h00ABC01E);
        m.slow = 0;
        $display("refusal test done");
        SYS_RST <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        rc(a_even, 32'h0);
        rc(a_idx, 32'h0);
        rc(a_wired, 32'h0);
        $display("second reset test done");
        give_verdict;
    end
endmodule
bind tlb_entry_staging_regs tlb_stage_chk chk (.*);

/* verification/tlb_stage_chk.sv */
`timescale 1ns/1ps
module tlb_stage_chk (
    input wire        REF_CLK,
    input wire        SYS_RST,
    input wire [1:0]  S_AXI_BRESP,
    input wire        S_AXI_BVALID,
    input wire        S_AXI_BREADY,
    input wire [7:0]  S_AXI_ARADDR,
    input wire        S_AXI_ARVALID,
    input wire        S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0]  S_AXI_RRESP,
    input wire        S_AXI_RVALID,
    input wire        S_AXI_RREADY
);
    reg  [7:0] ra_q;
    wire       ok = S_AXI_RVALID && S_AXI_RRESP == 2'h0;

    // Address of the read now being answered
    always @(posedge REF_CLK) begin
        if (SYS_RST)
            ra_q <= 8'h00;
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
            ra_q <= S_AXI_ARADDR;
    end

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    AST_RD_NEXT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    AST_RD_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
    AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
    AST_AR_BUSY: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while busy");
    AST_ENT_RSV: assert property (ok && (ra_q == 8'h08 || ra_q == 8'h0C)
        |-> S_AXI_RDATA[31:30] == 2'h0) else $error("entry top bits set");
    AST_PTR_LOW: assert property (ok && ra_q == 8'h10 |-> S_AXI_RDATA[3:0] == 4'h0)
        else $error("pointer low bits set");
    AST_COH: assert property (ok && ra_q == 8'h28 && S_AXI_RDATA[7]
        |-> S_AXI_RDATA[11:9] inside {3'h2, 3'h3}
        && S_AXI_RDATA[8] == (S_AXI_RDATA[11:9] == 3'h2)) else $error("bad coherency");
    AST_UNMAP: assert property (S_AXI_RVALID && ra_q > 8'h28
        |-> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0) else $error("unmapped read");
endmodule

/* verification/tlb_stage_host.sv */
`timescale 1ns/1ps
module tlb_stage_host (
    input  wire        REF_CLK,
    output reg  [7:0]  S_AXI_AWADDR,
    output reg         S_AXI_AWVALID,
    input  wire        S_AXI_AWREADY,
    output reg  [31:0] S_AXI_WDATA,
    output reg  [3:0]  S_AXI_WSTRB,
    output reg         S_AXI_WVALID,
    input  wire        S_AXI_WREADY,
    input  wire [1:0]  S_AXI_BRESP,
    input  wire        S_AXI_BVALID,
    output reg         S_AXI_BREADY,
    output reg  [7:0]  S_AXI_ARADDR,
    output reg         S_AXI_ARVALID,
    input  wire        S_AXI_ARREADY,
    input  wire [31:0] S_AXI_RDATA,
    input  wire [1:0]  S_AXI_RRESP,
    input  wire        S_AXI_RVALID,
    output reg         S_AXI_RREADY
);
    integer slow = 0;
    initial begin
        {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID} = 0;
        {S_AXI_BREADY, S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = 0;
        S_AXI_WSTRB = 4'hF;
    end
    // Released payload is inverted so stale values never look valid
    task wr(input [7:0] a, input [31:0] d, output [1:0] r);
        reg aw, wd;
        begin
            @(posedge REF_CLK);
            S_AXI_AWADDR <= a;
            S_AXI_WDATA <= d;
            S_AXI_AWVALID <= 1'b1;
            S_AXI_WVALID <= 1'b1;
            aw = 1'b1;
            wd = 1'b1;
            while (aw || wd) begin
                @(posedge REF_CLK);
                if (aw && S_AXI_AWREADY) begin
                    aw = 1'b0;
                    S_AXI_AWVALID <= 1'b0;
                    S_AXI_AWADDR <= ~a;
                end
                if (wd && S_AXI_WREADY) begin
                    wd = 1'b0;
                    S_AXI_WVALID <= 1'b0;
                    S_AXI_WDATA <= ~d;
                end
            end
            repeat (slow) @(posedge REF_CLK);
            S_AXI_BREADY <= 1'b1;
            do @(posedge REF_CLK); while (!S_AXI_BVALID);
            r = S_AXI_BRESP;
            S_AXI_BREADY <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge REF_CLK);
            S_AXI_ARADDR <= a;
            S_AXI_ARVALID <= 1'b1;
            do @(posedge REF_CLK); while (!S_AXI_ARREADY);
            S_AXI_ARVALID <= 1'b0;
            S_AXI_ARADDR <= ~a;
            repeat (slow) @(posedge REF_CLK);
            S_AXI_RREADY <= 1'b1;
            do @(posedge REF_CLK); while (!S_AXI_RVALID);
            d = S_AXI_RDATA;
            r = S_AXI_RRESP;
            S_AXI_RREADY <= 1'b0;
        end
    endtask
endmodule
